// ### hdl/aess_cfg.svh
`ifndef AESS_CFG_SVH
`define AESS_CFG_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define AESS_ADDR_W            8
`define AESS_ERROR_SUMMARY_OFF 8'h44
`define AESS_ERROR_SUMMARY_RST 32'h0000_0000

// ----------------------------------------------------------------------------
// Field positions of the error summary register
// ----------------------------------------------------------------------------
`define AESS_SENT_HI           16
`define AESS_SENT_LO           13
`define AESS_ADAPTER_PEND_BIT  12
`define AESS_BUS_PEND_HI       11
`define AESS_BUS_PEND_LO       8
`define AESS_REPEAT_ERR_BIT    7
`define AESS_CMD_FAIL_BIT      6
`define AESS_ILLEGAL_CMD_BIT   3
`define AESS_PARITY_ERR_BIT    0

// ----------------------------------------------------------------------------
// Interrupt levels: index 0 is the lowest level served, index 3 the highest.
// ----------------------------------------------------------------------------
`define AESS_LEVEL_COUNT       4
`define AESS_ADAPTER_LEVEL     2'h3

`endif

// ### hdl/aess_pkg.sv
`default_nettype none

package aess_pkg;

    // ------------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------------
    typedef logic [1:0] aess_level_t;
    typedef logic [3:0] aess_level_mask_t;

    typedef struct packed {
        aess_level_mask_t flags;
    } aess_flags_state_t;

    typedef struct packed {
        logic             parity_err;
        logic             illegal_cmd;
        logic             cmd_fail;
        logic             repeat_err;
        logic             ca_txn_err;
        logic             adapter_pend;
        aess_level_mask_t request;
        logic [31:0]      rd_data;
    } aess_main_state_t;

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    function automatic aess_level_mask_t level_mask(input aess_level_t level);
        level_mask = 4'h1 << level;
    endfunction

endpackage

`default_nettype wire

// ### hdl/aess_level_flags.sv
`timescale 1ns/1ps
`default_nettype none

// One sticky flag per interrupt level; a set at a level wins over a clear
// arriving at that same level in the same cycle.
module aess_level_flags (
    input  wire logic                    clk,
    input  wire logic                    reset,
    input  wire logic                    set_valid,
    input  wire aess_pkg::aess_level_t   set_level,
    input  wire logic                    clear_valid,
    input  wire aess_pkg::aess_level_t   clear_level,
    output logic [3:0]                   flags
);

    aess_pkg::aess_flags_state_t state_reg;
    aess_pkg::aess_flags_state_t state_next;

    always_comb
    begin
        state_next = state_reg;
        if (clear_valid)
        begin
            state_next.flags = state_next.flags & ~aess_pkg::level_mask(clear_level);
        end
        if (set_valid)
        begin
            state_next.flags = state_next.flags | aess_pkg::level_mask(set_level);
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign flags = state_reg.flags;

endmodule

`default_nettype wire

// ### hdl/aess_regs.sv
// Notes on behaviour
// - The error summary register answers at byte offset 0x44 of the node register space.
// - Bits 16 to 13 read the four interrupt-sent flags, bit 16 for the highest level.
// - Per-level pending state combines the sent flags with the pending flags of bits 12 to 8.
// - Bit 12 is read-only, resets to zero and reads one while the adapter's own interrupt pends.
// - A pending bit of bits 11 to 8 sets on a received bus-side interrupt and holds until an identify at its level.
// - Bits 11 to 8 read the bus-side pending flags directly, bit 8 for the lowest level.
// - Bit 7 sets on a fetch parity error while bits 3 and 0 stand, and clears on a write of one.
// - A write-data parity error in the transaction whose command fetch failed does not set bit 7.
// - Bit 6 is read-only, resets to zero and with bit 0 marks a parity error on a command fetch.
// - Bit 0 records an internal module bus parity error seen by the fetch logic.
// - Bit 3 is write-one-to-clear and sets when an illegal processor command is decoded.

`timescale 1ns/1ps
`default_nettype none

`include "aess_cfg.svh"

module aess_regs (
    input  wire logic                     clk,
    input  wire logic                     reset,
    input  wire logic [`AESS_ADDR_W-1:0]  reg_addr,
    input  wire logic [31:0]              reg_wdata,
    input  wire logic                     reg_write,
    input  wire logic                     reg_read,
    output logic [31:0]                   reg_rdata,
    input  wire logic                     bus_int_recv,
    input  wire aess_pkg::aess_level_t    bus_int_level,
    input  wire logic                     adapter_int_raise,
    input  wire logic                     int_sent,
    input  wire aess_pkg::aess_level_t    int_sent_level,
    input  wire logic                     ident_valid,
    input  wire aess_pkg::aess_level_t    ident_level,
    input  wire logic                     fetch_done,
    input  wire logic                     fetch_is_ca,
    input  wire logic                     fetch_parity_err,
    input  wire logic                     illegal_cmd,
    output logic [3:0]                    interrupt_request
);

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    aess_pkg::aess_main_state_t state_reg;
    aess_pkg::aess_main_state_t state_next;

    logic [3:0]  bus_pend;
    logic [3:0]  sent_flags;
    logic [3:0]  ident_mask;
    logic [3:0]  adapter_mask;
    logic        reg_hit;
    logic        hit_write;
    logic        fetch_err;
    logic        exempt_fetch;
    logic [31:0] reg_image;

    // ------------------------------------------------------------------------
    // Interrupt level flags
    // ------------------------------------------------------------------------
    // Identify clears the received flag at its level.
    aess_level_flags u_bus_pend (
        .clk         (clk),
        .reset       (reset),
        .set_valid   (bus_int_recv),
        .set_level   (bus_int_level),
        .clear_valid (ident_valid),
        .clear_level (ident_level),
        .flags       (bus_pend)
    );

    // Sent flags drop once the identify for that level has been served.
    aess_level_flags u_sent (
        .clk         (clk),
        .reset       (reset),
        .set_valid   (int_sent),
        .set_level   (int_sent_level),
        .clear_valid (ident_valid),
        .clear_level (ident_level),
        .flags       (sent_flags)
    );

    // ------------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------------
    always_comb
    begin
        if (reg_addr == `AESS_ERROR_SUMMARY_OFF)
        begin
            reg_hit = 1'b1;
        end
        else
        begin
            reg_hit = 1'b0;
        end
    end

    assign hit_write    = reg_write && reg_hit;
    assign ident_mask   = ident_valid ? aess_pkg::level_mask(ident_level) : 4'h0;
    assign adapter_mask = state_reg.adapter_pend
                        ? aess_pkg::level_mask(`AESS_ADAPTER_LEVEL) : 4'h0;
    assign fetch_err    = fetch_done && fetch_parity_err;
    // A write-data fetch belongs to the transaction whose command fetch came last.
    assign exempt_fetch = !fetch_is_ca && state_reg.ca_txn_err;

    // ------------------------------------------------------------------------
    // Read image
    // ------------------------------------------------------------------------
    always_comb
    begin
        reg_image = `AESS_ERROR_SUMMARY_RST;
        reg_image[`AESS_SENT_HI:`AESS_SENT_LO] = sent_flags;
        reg_image[`AESS_ADAPTER_PEND_BIT] = state_reg.adapter_pend;
        reg_image[`AESS_BUS_PEND_HI:`AESS_BUS_PEND_LO] = bus_pend;
        reg_image[`AESS_REPEAT_ERR_BIT] = state_reg.repeat_err;
        reg_image[`AESS_CMD_FAIL_BIT] = state_reg.cmd_fail;
        reg_image[`AESS_ILLEGAL_CMD_BIT] = state_reg.illegal_cmd;
        reg_image[`AESS_PARITY_ERR_BIT] = state_reg.parity_err;
    end

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    // Every flag applies its clear first and its set after, so an event in
    // the clearing cycle survives.
    always_comb
    begin
        state_next = state_reg;

        // The fetch qualifiers look at the flags as they stood before this
        // fetch, which is what makes the error a repeat.
        if (hit_write && reg_wdata[`AESS_REPEAT_ERR_BIT])
        begin
            state_next.repeat_err = 1'b0;
        end
        if (fetch_err && state_reg.illegal_cmd && state_reg.parity_err && !exempt_fetch)
        begin
            state_next.repeat_err = 1'b1;
        end

        if (fetch_done && fetch_is_ca)
        begin
            state_next.ca_txn_err = fetch_parity_err;
        end

        // The qualifier has no clear of its own; it follows the parity flag.
        if (hit_write && reg_wdata[`AESS_PARITY_ERR_BIT])
        begin
            state_next.parity_err = 1'b0;
            state_next.cmd_fail   = 1'b0;
        end
        if (fetch_err)
        begin
            state_next.parity_err = 1'b1;
        end
        if (fetch_err && fetch_is_ca)
        begin
            state_next.cmd_fail = 1'b1;
        end

        if (hit_write && reg_wdata[`AESS_ILLEGAL_CMD_BIT])
        begin
            state_next.illegal_cmd = 1'b0;
        end
        if (illegal_cmd)
        begin
            state_next.illegal_cmd = 1'b1;
        end

        if (ident_mask[`AESS_ADAPTER_LEVEL])
        begin
            state_next.adapter_pend = 1'b0;
        end
        if (adapter_int_raise)
        begin
            state_next.adapter_pend = 1'b1;
        end

        // A level still needs a request while something pends there and the
        // request has not gone out yet.
        state_next.request = (bus_pend | adapter_mask) & ~sent_flags;

        state_next.rd_data = 32'h0000_0000;
        if (reg_read && reg_hit)
        begin
            state_next.rd_data = reg_image;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign reg_rdata         = state_reg.rd_data;
    assign interrupt_request = state_reg.request;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence s_armed;
        state_reg.illegal_cmd && state_reg.parity_err;
    endsequence

    sequence s_new_error;
        fetch_err && !exempt_fetch;
    endsequence

    sequence s_same_txn_error;
        fetch_err && exempt_fetch && !state_reg.repeat_err;
    endsequence

    a_read_offset_hit: assert property (
        (reg_read && reg_addr == `AESS_ERROR_SUMMARY_OFF) |=>
            reg_rdata == $past(reg_image))
        else $error("read at the register offset returned a wrong image");

    a_read_unmapped: assert property (
        (reg_read && reg_addr != `AESS_ERROR_SUMMARY_OFF) |=> reg_rdata == 32'h0000_0000)
        else $error("unmapped read returned nonzero data");

    a_upper_zero: assert property (
        reg_rdata[31:17] == 15'h0000 && reg_rdata[5:4] == 2'h0)
        else $error("reserved bits read nonzero");

    a_sent_readback: assert property (
        (reg_read && reg_hit) |=> reg_rdata[16:13] == $past(sent_flags))
        else $error("sent field does not follow the sent flags");

    a_sent_set: assert property (
        int_sent |=> sent_flags[$past(int_sent_level)])
        else $error("sent flag did not set on a sent interrupt");

    a_bus_pend_set: assert property (
        bus_int_recv |=> bus_pend[$past(bus_int_level)])
        else $error("bus pending flag did not set on a received interrupt");

    a_bus_pend_hold: assert property (
        1'b1 |=> ((bus_pend & ($past(bus_pend) & ~$past(ident_mask)))
                  == ($past(bus_pend) & ~$past(ident_mask))))
        else $error("bus pending flag dropped without an identify");

    a_pend_readback: assert property (
        (reg_read && reg_hit) |=> reg_rdata[11:8] == $past(bus_pend)
                                  && reg_rdata[12] == $past(state_reg.adapter_pend))
        else $error("pending field is not a direct read of the flags");

    a_request_derived: assert property (
        1'b1 |=> interrupt_request ==
            (($past(bus_pend) | $past(adapter_mask)) & ~$past(sent_flags)))
        else $error("interrupt request does not follow pending and sent state");

    a_repeat_set: assert property (
        s_armed and s_new_error |=> state_reg.repeat_err)
        else $error("repeated fetch error was not flagged");

    a_repeat_exempt: assert property (
        s_same_txn_error |=> !state_reg.repeat_err)
        else $error("data parity error of the same transaction flagged as repeat");

    a_illegal_w1c: assert property (
        (hit_write && reg_wdata[3] && !illegal_cmd) |=> !state_reg.illegal_cmd)
        else $error("write of one did not clear the illegal command flag");

    a_set_beats_clear: assert property (
        (hit_write && reg_wdata[3] && illegal_cmd) |=> state_reg.illegal_cmd)
        else $error("illegal command event lost against a clear");

    a_cmd_fail_pair: assert property (
        (fetch_err && fetch_is_ca) |=> state_reg.cmd_fail && state_reg.parity_err)
        else $error("command fetch failure not marked with the parity flag");

    a_parity_set: assert property (
        fetch_err |=> state_reg.parity_err)
        else $error("parity flag did not set on a fetch error");

    // Clearing bit 0 also drops bit 6, since bit 6 means nothing without it.
    a_parity_w1c: assert property (
        (hit_write && reg_wdata[0] && !fetch_err) |=>
            !state_reg.parity_err && !state_reg.cmd_fail)
        else $error("write of one did not clear the parity flags");

    a_rdata_idle: assert property (
        !reg_read |=> reg_rdata == 32'h0000_0000)
        else $error("read data stood outside the cycle after a read");

    a_adapter_set: assert property (
        adapter_int_raise |=> state_reg.adapter_pend)
        else $error("adapter pending flag did not set");

    a_ident_clear: assert property (
        (ident_valid && !bus_int_recv) |=> !bus_pend[$past(ident_level)])
        else $error("identify did not clear the bus pending flag");

endmodule

`default_nettype wire

// ### sim/aess_event_src.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// Event source standing for the adapter core around the register block
// ----------------------------------------------------------------------------
// Kinds: 0 bus interrupt received, 1 interrupt sent, 2 identify, 3 adapter
// interrupt raised, 4 illegal command. Qualifiers are inverted once a pulse
// ends, so the design cannot pass by looking at stale level lines.
module aess_event_src (
    input  wire logic             clk,
    output aess_pkg::aess_level_t bus_int_level,
    output aess_pkg::aess_level_t int_sent_level,
    output aess_pkg::aess_level_t ident_level,
    output logic                  bus_int_recv,
    output logic                  adapter_int_raise,
    output logic                  int_sent,
    output logic                  ident_valid,
    output logic                  illegal_cmd,
    output logic                  fetch_done,
    output logic                  fetch_is_ca,
    output logic                  fetch_parity_err
);
    initial
    begin
        {bus_int_recv, adapter_int_raise, int_sent, ident_valid, illegal_cmd} = '0;
        {fetch_done, fetch_is_ca, fetch_parity_err} = '0;
        {bus_int_level, int_sent_level, ident_level} = '0;
    end

    task automatic ev(input int k, input aess_pkg::aess_level_t l);
        @(posedge clk);
        bus_int_recv      <= (k == 0);
        int_sent          <= (k == 1);
        ident_valid       <= (k == 2);
        adapter_int_raise <= (k == 3);
        illegal_cmd       <= (k == 4);
        bus_int_level     <= l;
        int_sent_level    <= l;
        ident_level       <= l;
        @(posedge clk);
        {bus_int_recv, adapter_int_raise, int_sent, ident_valid, illegal_cmd} <= '0;
        bus_int_level     <= ~l;
        int_sent_level    <= ~l;
        ident_level       <= ~l;
    endtask

    // A write-data fetch is only ever issued after its command fetch.
    task automatic fetch(input logic ca, input logic err);
        @(posedge clk);
        fetch_done       <= 1'b1;
        fetch_is_ca      <= ca;
        fetch_parity_err <= err;
        @(posedge clk);
        fetch_done       <= 1'b0;
        fetch_is_ca      <= ~ca;
        fetch_parity_err <= ~err;
    endtask
endmodule

`default_nettype wire

// ### sim/adapter_error_summary_status_tb.sv
`timescale 1ns/1ps
`default_nettype none

`include "aess_cfg.svh"

module adapter_error_summary_status_tb;
    localparam logic [7:0] OFF = `AESS_ERROR_SUMMARY_OFF;

    logic                  clk;
    logic                  reset;
    logic [7:0]            reg_addr;
    logic [31:0]           reg_wdata;
    logic                  reg_write;
    logic                  reg_read;
    logic [31:0]           reg_rdata;
    logic [3:0]            interrupt_request;
    aess_pkg::aess_level_t bus_int_level;
    aess_pkg::aess_level_t int_sent_level;
    aess_pkg::aess_level_t ident_level;
    logic                  bus_int_recv;
    logic                  adapter_int_raise;
    logic                  int_sent;
    logic                  ident_valid;
    logic                  illegal_cmd;
    logic                  fetch_done;
    logic                  fetch_is_ca;
    logic                  fetch_parity_err;
    int                    n_mismatch;
    int                    compares;
    int                    cycles;
    logic [31:0]           pend;

    aess_regs u_aess_regs (
        .clk               (clk),
        .reset             (reset),
        .reg_addr          (reg_addr),
        .reg_wdata         (reg_wdata),
        .reg_write         (reg_write),
        .reg_read          (reg_read),
        .reg_rdata         (reg_rdata),
        .bus_int_recv      (bus_int_recv),
        .bus_int_level     (bus_int_level),
        .adapter_int_raise (adapter_int_raise),
        .int_sent          (int_sent),
        .int_sent_level    (int_sent_level),
        .ident_valid       (ident_valid),
        .ident_level       (ident_level),
        .fetch_done        (fetch_done),
        .fetch_is_ca       (fetch_is_ca),
        .fetch_parity_err  (fetch_parity_err),
        .illegal_cmd       (illegal_cmd),
        .interrupt_request (interrupt_request)
    );

    aess_event_src u_aess_event_src (
        .clk               (clk),
        .bus_int_level     (bus_int_level),
        .int_sent_level    (int_sent_level),
        .ident_level       (ident_level),
        .bus_int_recv      (bus_int_recv),
        .adapter_int_raise (adapter_int_raise),
        .int_sent          (int_sent),
        .ident_valid       (ident_valid),
        .illegal_cmd       (illegal_cmd),
        .fetch_done        (fetch_done),
        .fetch_is_ca       (fetch_is_ca),
        .fetch_parity_err  (fetch_parity_err)
    );

    // ------------------------------------------------------------------------
    // Clock, time limit and verdict
    // ------------------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic stop_test();
        if (n_mismatch == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // The whole sequence needs well under a thousand cycles.
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_mismatch++;
            stop_test();
        end
    end

    // ------------------------------------------------------------------------
    // Register port access and comparison
    // ------------------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_write <= 1'b0;
        reg_wdata <= ~d;
    endtask

    // Read data stand only in the cycle after the strobe, so sample there.
    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        chk(name, exp, reg_rdata);
    endtask

    // ------------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------------
    initial
    begin
        n_mismatch = 0;
        compares   = 0;
        reset      = 1'b1;
        reg_addr   = 8'h00;
        reg_wdata  = 32'h0000_0000;
        reg_write  = 1'b0;
        reg_read   = 1'b0;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rd_chk("reset image", OFF, `AESS_ERROR_SUMMARY_RST);
        rd_chk("unmapped read", 8'h40, 32'h0000_0000);
        for (int l = 0; l < 4; l++)
        begin
            pend = 32'h1 << (`AESS_BUS_PEND_LO + l);
            u_aess_event_src.ev(0, l[1:0]);
            rd_chk("bus pending", OFF, pend);
            chk("request", 32'h1 << l, {28'h0, interrupt_request});
            u_aess_event_src.ev(1, l[1:0]);
            rd_chk("sent", OFF, pend | (32'h1 << (`AESS_SENT_LO + l)));
            chk("request sent", 32'h0, {28'h0, interrupt_request});
            wr(OFF, 32'hffff_ffff);
            rd_chk("read-only", OFF, pend | (32'h1 << (`AESS_SENT_LO + l)));
            u_aess_event_src.ev(2, l[1:0]);
            rd_chk("identify", OFF, 32'h0000_0000);
        end
        u_aess_event_src.ev(3, 2'h0);
        rd_chk("adapter pending", OFF, 32'h0000_1000);
        chk("adapter request", 32'h8, {28'h0, interrupt_request});
        u_aess_event_src.ev(2, `AESS_ADAPTER_LEVEL);
        rd_chk("adapter identify", OFF, 32'h0000_0000);
        // The illegal command event and its clear land on the same edge.
        fork
            u_aess_event_src.ev(4, 2'h0);
            wr(OFF, 32'h0000_0008);
        join
        rd_chk("illegal cmd", OFF, 32'h0000_0008);
        u_aess_event_src.fetch(1'b1, 1'b1);
        rd_chk("ca parity", OFF, 32'h0000_0049);
        u_aess_event_src.fetch(1'b0, 1'b1);
        rd_chk("same txn", OFF, 32'h0000_0049);
        u_aess_event_src.fetch(1'b1, 1'b1);
        rd_chk("repeat err", OFF, 32'h0000_00c9);
        wr(8'h40, 32'hffff_ffff);
        rd_chk("unmapped write", OFF, 32'h0000_00c9);
        wr(OFF, 32'h0000_0088);
        rd_chk("w1c clear", OFF, 32'h0000_0041);
        u_aess_event_src.ev(4, 2'h0);
        u_aess_event_src.fetch(1'b1, 1'b0);
        u_aess_event_src.fetch(1'b0, 1'b1);
        rd_chk("clean ca then data", OFF, 32'h0000_00c9);
        wr(OFF, 32'h0000_0089);
        rd_chk("parity clear", OFF, 32'h0000_0000);
        u_aess_event_src.ev(0, 2'h1);
        u_aess_event_src.ev(4, 2'h0);
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rd_chk("mid-run reset", OFF, `AESS_ERROR_SUMMARY_RST);
        chk("reset request", 32'h0, {28'h0, interrupt_request});
        stop_test();
    end
endmodule

`default_nettype wire
